// ===== hdl/deser_defines.svh
// Summary of operation
// (R1) two missed clock edges drop lock
// (R2) unlocked channel hunts for framing by itself
// (R3) system feeds lock back to sync request
// (R4) sleeping channel stops, outputs held high
// (R5) channel sleep affects only that channel
// (R6) global sleep forces all outputs high
// (R7) all six channel sleeps equal global sleep
// (R8) sleep and enable inputs default low
// (R9) leaving sleep enters initialization
// (R10) drive enable low floats data, clock only
// (R11) drive enable restored resumes prior state
// (R12) scan control floats every output first
// (R13) global sleep ranks second
// (R14) channel sleep outranks drive enable
// (R15) unlocked drives high, locked drives data
// (R16) standalone test obeys all overrides; the code floats every output while it runs
// (R17) scan overrides sleep and enable
// (R18) external test captures serial input levels
// (R19) self-test runs for fixed frame count
// (R20) result holds done and pass per channel
// (R21) pass only when error rate below limit
// (R22) both test controllers start close together
`ifndef DESER_DEFINES_SVH
`define DESER_DEFINES_SVH
`define NCH 6
`define DW 10
`define FRAME_LAST 4'hb
`define RCLK_RISE 4'h6
`define LOCK_FRAMES 7'h50
`define PIN_LCLK 0
`define PIN_LDAT 6
`define PIN_SLP 12
`define PIN_GSLP 18
`define PIN_REN 19
`define PIN_HIZN 20
`define PIN_BIST 21
`define NPIN 22
`define BIST_TIME_US 33000
`define SYS_CLK_KHZ 66000
`define BIST_FRAMES (`BIST_TIME_US * (`SYS_CLK_KHZ / 1000))
`define BER_DENOM 10000000
`define BFR_W 22
`define ERR_W 8
`endif

// ===== hdl/deser_pkg.sv
`include "deser_defines.svh"
package deser_pkg;
  typedef enum logic [1:0] {
    CH_SLEEP = 2'b00,
    CH_INIT = 2'b01,
    CH_LOCKED = 2'b10,
    CH_RESYNC = 2'b11
  } ch_state_t;
  typedef logic [`NCH-1:0][`DW-1:0] data_bus_t;
  typedef logic [`NCH-1:0] ch_vec_t;
  typedef logic [2*`NCH-1:0] result_t;
  typedef struct packed {
    logic [`NPIN-1:0] s1;
    logic [`NPIN-1:0] s2;
    logic [`NPIN-1:0] s3;
    logic [`NPIN-1:0] pin;
    ch_state_t [`NCH-1:0] st;
    logic [`NCH-1:0][3:0] bitcnt;
    logic [`NCH-1:0][11:0] sr;
    logic [`NCH-1:0][6:0] good;
    ch_vec_t miss;
    data_bus_t word;
    ch_vec_t rclk_int;
    data_bus_t dout;
    ch_vec_t doe;
    ch_vec_t rclk;
    ch_vec_t coe;
    ch_vec_t lock_n;
    ch_vec_t loe;
    logic bist_prev;
    logic [`NCH-1:0][`BFR_W-1:0] bfr;
    logic [`NCH-1:0][`ERR_W-1:0] berr;
    data_bus_t bprev;
    ch_vec_t bfirst;
    result_t result;
    ch_vec_t extest;
  } state_t;
endpackage

// ===== hdl/deser_control.sv
`timescale 1ns/1ps
`include "deser_defines.svh"
module deser_control
#(
  parameter int BIST_FRAMES = `BIST_FRAMES
)
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire deser_pkg::ch_vec_t LINK_CLK,
  input wire deser_pkg::ch_vec_t LINK_DATA,
  input wire deser_pkg::ch_vec_t CHANNEL_SLEEP_N,
  input wire logic GLOBAL_SLEEP_N,
  input wire logic OUTPUT_DRIVE_ENABLE,
  input wire logic SCAN_HIGHZ_N,
  input wire logic SCAN_SELFTEST_ACTIVE,
  output logic [`NCH*`DW-1:0] RECOVERED_DATA_OUT,
  output deser_pkg::ch_vec_t RECOVERED_DATA_OE,
  output deser_pkg::ch_vec_t CHANNEL_RECOVERED_CLOCK,
  output deser_pkg::ch_vec_t CHANNEL_RECOVERED_CLOCK_OE,
  output deser_pkg::ch_vec_t CHANNEL_LOCK_N,
  output deser_pkg::ch_vec_t CHANNEL_LOCK_N_OE,
  output deser_pkg::result_t SELFTEST_RESULT_CHAIN,
  output deser_pkg::ch_vec_t EXTEST_CAPTURE
);
  import deser_pkg::*;

  localparam int ERR_LIMIT = (BIST_FRAMES * `DW - 1) / `BER_DENOM;

  state_t cur_reg;
  state_t cur_next;
  logic [`NPIN-1:0] pins;
  ch_vec_t lclk_edge;
  ch_vec_t bit_in;
  ch_vec_t slp_n;
  ch_vec_t sleep_c;
  logic scan_off;
  logic bias_off;
  logic bist_on;
  logic bist_start;
  logic [11:0] sr_new;
  logic [`DW-1:0] word_new;

  // start bit high in the oldest slot, stop bit low in the newest
  function automatic logic frame_ok(input logic [11:0] f);
    frame_ok = f[11] & ~f[0];
  endfunction

  // first data bit arrives right after the start bit
  function automatic logic [`DW-1:0] frame_word(input logic [11:0] f);
    logic [`DW-1:0] w;
    w = '0;
    for (int i = 0; i < `DW; i++)
    begin
      w[i] = f[10-i];
    end
    frame_word = w;
  endfunction

  function automatic logic [`ERR_W-1:0] sat_add(
    input logic [`ERR_W-1:0] a,
    input logic [3:0] b
  );
    logic [`ERR_W:0] s;
    s = {1'b0, a} + {{(`ERR_W-3){1'b0}}, b};
    sat_add = s[`ERR_W] ? '1 : s[`ERR_W-1:0];
  endfunction

  function automatic logic [3:0] bit_errs(
    input logic [`DW-1:0] a,
    input logic [`DW-1:0] b
  );
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < `DW; i++)
    begin
      n = n + {3'h0, a[i] ^ b[i]};
    end
    bit_errs = n;
  endfunction

  assign pins = {SCAN_SELFTEST_ACTIVE, ~SCAN_HIGHZ_N, OUTPUT_DRIVE_ENABLE,
                 GLOBAL_SLEEP_N, CHANNEL_SLEEP_N, LINK_DATA, LINK_CLK};

  always_comb
  begin
    sr_new = '0;
    word_new = '0;
    cur_next = cur_reg;
    cur_next.s1 = pins;
    cur_next.s2 = cur_reg.s1;
    cur_next.s3 = cur_reg.s2;
    // a bit sets once the second and third stages agree high, and clears as soon as they differ
    cur_next.pin = (cur_reg.s2 & cur_reg.s3)
                 | (cur_reg.pin & ~(cur_reg.s2 ^ cur_reg.s3));
    lclk_edge = cur_next.pin[`PIN_LCLK +: `NCH] & ~cur_reg.pin[`PIN_LCLK +: `NCH];
    bit_in = cur_next.pin[`PIN_LDAT +: `NCH];
    slp_n = cur_reg.pin[`PIN_SLP +: `NCH];
    scan_off = cur_reg.pin[`PIN_HIZN] | cur_reg.pin[`PIN_BIST]; // see (R12)
    bias_off = ~cur_reg.pin[`PIN_GSLP] | ~|slp_n; // see (R6) see (R7)
    bist_on = cur_reg.pin[`PIN_BIST];
    bist_start = bist_on & ~cur_reg.bist_prev;
    cur_next.bist_prev = bist_on;
    if (cur_reg.pin[`PIN_HIZN])
    begin
      // go/no-go level check of the serial inputs
      cur_next.extest = cur_reg.pin[`PIN_LDAT +: `NCH]; // see (R18)
    end
    if (bist_start)
    begin
      cur_next.result = '0;
    end
    for (int c = 0; c < `NCH; c++)
    begin
      sleep_c[c] = bias_off | ~slp_n[c]; // see (R5)
      if (sleep_c[c])
      begin
        // recovery loop halted; state is rebuilt on wake
        cur_next.st[c] = CH_SLEEP; // see (R4)
        cur_next.bitcnt[c] = '0;
        cur_next.good[c] = '0;
        cur_next.miss[c] = 1'b0;
        cur_next.rclk_int[c] = 1'b1;
      end
      else if (cur_reg.st[c] == CH_SLEEP)
      begin
        cur_next.st[c] = CH_INIT; // see (R9)
      end
      else if (lclk_edge[c])
      begin
        sr_new = {cur_reg.sr[c][10:0], bit_in[c]};
        word_new = frame_word(sr_new);
        cur_next.sr[c] = sr_new;
        cur_next.bitcnt[c] = cur_reg.bitcnt[c] + 4'h1;
        if (cur_reg.bitcnt[c] == `RCLK_RISE)
        begin
          cur_next.rclk_int[c] = 1'b1;
        end
        if (cur_reg.bitcnt[c] == `FRAME_LAST)
        begin
          cur_next.bitcnt[c] = '0;
          if (cur_reg.st[c] == CH_LOCKED)
          begin
            if (frame_ok(sr_new))
            begin
              cur_next.miss[c] = 1'b0;
              cur_next.word[c] = word_new;
              cur_next.rclk_int[c] = 1'b0;
              if (bist_on && cur_reg.bfr[c] != `BFR_W'(BIST_FRAMES))
              begin
                cur_next.bfr[c] = cur_reg.bfr[c] + `BFR_W'(1);
                cur_next.bfirst[c] = 1'b0;
                cur_next.bprev[c] = word_new;
                if (!cur_reg.bfirst[c])
                begin
                  // partner sends a counting pattern
                  cur_next.berr[c] = sat_add(cur_reg.berr[c],
                    bit_errs(word_new, cur_reg.bprev[c] + `DW'(1))); // see (R21)
                end
              end
            end
            else if (cur_reg.miss[c])
            begin
              // second miss in a row: lock is gone, hunt again
              cur_next.st[c] = CH_RESYNC; // see (R1) see (R2)
              cur_next.good[c] = '0;
            end
            else
            begin
              cur_next.miss[c] = 1'b1;
              if (bist_on)
              begin
                cur_next.berr[c] = sat_add(cur_reg.berr[c], 4'(`DW));
              end
            end
          end
          else if (frame_ok(sr_new))
          begin
            cur_next.good[c] = cur_reg.good[c] + 7'h1;
            if (cur_reg.good[c] == `LOCK_FRAMES - 7'h1)
            begin
              cur_next.st[c] = CH_LOCKED; // see (R2)
              cur_next.miss[c] = 1'b0;
            end
          end
          else
          begin
            // slip one bit so the next edge tests a shifted window
            cur_next.good[c] = '0;
            cur_next.bitcnt[c] = `FRAME_LAST; // see (R2)
          end
        end
      end
      if (bist_start)
      begin
        cur_next.bfr[c] = '0;
        cur_next.berr[c] = '0;
        cur_next.bfirst[c] = 1'b1;
      end
      else if (cur_reg.bfr[c] == `BFR_W'(BIST_FRAMES))
      begin
        cur_next.result[2*c+1] = 1'b1; // see (R19) see (R20)
        cur_next.result[2*c] = cur_reg.berr[c] <= `ERR_W'(ERR_LIMIT); // see (R21)
      end
      // output priority: scan, global sleep, channel sleep, enable, lock
      if (scan_off)
      begin
        cur_next.dout[c] = '1; // see (R12) see (R17) see (R16)
        cur_next.rclk[c] = 1'b1;
        cur_next.lock_n[c] = 1'b1;
        cur_next.doe[c] = 1'b0;
        cur_next.coe[c] = 1'b0;
        cur_next.loe[c] = 1'b0;
      end
      else if (sleep_c[c])
      begin
        cur_next.dout[c] = '1; // see (R13) see (R14) see (R6)
        cur_next.rclk[c] = 1'b1;
        cur_next.lock_n[c] = 1'b1;
        cur_next.doe[c] = 1'b1;
        cur_next.coe[c] = 1'b1;
        cur_next.loe[c] = 1'b1;
      end
      else
      begin
        // enable only gates drivers, channel state is untouched
        cur_next.doe[c] = cur_reg.pin[`PIN_REN]; // see (R10) see (R11)
        cur_next.coe[c] = cur_reg.pin[`PIN_REN];
        cur_next.loe[c] = 1'b1;
        cur_next.lock_n[c] = cur_reg.st[c] != CH_LOCKED; // see (R3)
        if (cur_reg.st[c] == CH_LOCKED)
        begin
          cur_next.dout[c] = cur_reg.word[c]; // see (R15)
          cur_next.rclk[c] = cur_reg.rclk_int[c];
        end
        else
        begin
          cur_next.dout[c] = '1; // see (R15)
          cur_next.rclk[c] = 1'b1;
        end
      end
    end
  end

  // pin stages reset to zero: sleep pins pull down, highz is kept inverted so no false float
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cur_reg <= '0; // see (R8)
      cur_reg.dout <= '1;
      cur_reg.doe <= '1;
      cur_reg.rclk <= '1;
      cur_reg.coe <= '1;
      cur_reg.lock_n <= '1;
      cur_reg.loe <= '1;
      cur_reg.rclk_int <= '1;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  assign RECOVERED_DATA_OUT = cur_reg.dout;
  assign RECOVERED_DATA_OE = cur_reg.doe;
  assign CHANNEL_RECOVERED_CLOCK = cur_reg.rclk;
  assign CHANNEL_RECOVERED_CLOCK_OE = cur_reg.coe;
  assign CHANNEL_LOCK_N = cur_reg.lock_n;
  assign CHANNEL_LOCK_N_OE = cur_reg.loe;
  assign SELFTEST_RESULT_CHAIN = cur_reg.result;
  assign EXTEST_CAPTURE = cur_reg.extest;

  property p_scan_float;
    @(posedge MCLK) disable iff (!RESETN)
    scan_off |=> (cur_reg.doe == '0) && (cur_reg.coe == '0) && (cur_reg.loe == '0);
  endproperty
  a_scan_float: assert property (p_scan_float) // see (R12)
    else $error("outputs driven under scan control");

  property p_global_high;
    @(posedge MCLK) disable iff (!RESETN)
    (!scan_off && !cur_reg.pin[`PIN_GSLP])
      |=> (cur_reg.dout == '1) && (cur_reg.lock_n == '1) && (cur_reg.doe == '1);
  endproperty
  a_global_high: assert property (p_global_high) // see (R13)
    else $error("global sleep did not force outputs high");

  property p_all_sleep;
    @(posedge MCLK) disable iff (!RESETN)
    (!scan_off && slp_n == '0) |=> (cur_reg.rclk == '1) && (cur_reg.coe == '1);
  endproperty
  a_all_sleep: assert property (p_all_sleep) // see (R7)
    else $error("all channel sleeps differ from global sleep");

  property p_ch_sleep;
    @(posedge MCLK) disable iff (!RESETN)
    (!scan_off && !slp_n[0] && !cur_reg.pin[`PIN_REN])
      |=> (cur_reg.dout[0] == '1) && cur_reg.doe[0] && (cur_reg.st[0] == CH_SLEEP);
  endproperty
  a_ch_sleep: assert property (p_ch_sleep) // see (R14)
    else $error("sleeping channel not driving high");

  property p_ren_float;
    @(posedge MCLK) disable iff (!RESETN)
    (!scan_off && !sleep_c[0] && !cur_reg.pin[`PIN_REN])
      |=> !cur_reg.doe[0] && !cur_reg.coe[0] && cur_reg.loe[0];
  endproperty
  a_ren_float: assert property (p_ren_float) // see (R10)
    else $error("drive enable low handled wrongly");

  property p_unlocked_high;
    @(posedge MCLK) disable iff (!RESETN)
    (!scan_off && !sleep_c[0] && cur_reg.st[0] != CH_LOCKED)
      |=> (cur_reg.dout[0] == '1) && cur_reg.lock_n[0];
  endproperty
  a_unlocked_high: assert property (p_unlocked_high) // see (R15)
    else $error("unlocked channel not high");

  property p_two_miss;
    @(posedge MCLK) disable iff (!RESETN)
    (!sleep_c[1] && cur_reg.st[1] == CH_LOCKED && lclk_edge[1] && cur_reg.miss[1]
      && cur_reg.bitcnt[1] == `FRAME_LAST && !frame_ok({cur_reg.sr[1][10:0], bit_in[1]}))
      |=> (cur_reg.st[1] == CH_RESYNC) ##1 (cur_reg.lock_n[1] || scan_off);
  endproperty
  a_two_miss: assert property (p_two_miss) // see (R1)
    else $error("second miss did not drop lock");

  property p_wake_init;
    @(posedge MCLK) disable iff (!RESETN)
    (cur_reg.st[0] == CH_SLEEP && !sleep_c[0]) |=> (cur_reg.st[0] == CH_INIT);
  endproperty
  a_wake_init: assert property (p_wake_init) // see (R9)
    else $error("wake did not enter initialization");

  property p_done_keeps;
    @(posedge MCLK) disable iff (!RESETN)
    (cur_reg.result[1] && !bist_start) |=> cur_reg.result[1];
  endproperty
  a_done_keeps: assert property (p_done_keeps) // see (R20)
    else $error("completion bit lost");
endmodule

// ===== verification/serializer_model.sv
`timescale 1ns/1ps
module serializer_model (
  input wire logic enable,
  input wire logic corrupt,
  input wire logic sync_request_a,
  output logic link_clk,
  output logic link_data
);
  logic [9:0] count_reg;
  logic [11:0] frame;
  initial
  begin
    link_clk = 1'b0;
    count_reg = 10'h000;
    frame = 12'h000;
    forever
    begin
      if (!enable)
      begin
        // released line shows the inverse of the last bit, clock parked
        link_data = ~frame[11];
        #80;
      end
      else
      begin
        // unlocked receiver gets sync words, locked one a counting pattern
        frame = {1'b0, sync_request_a ? 10'h03f : count_reg, 1'b1};
        if (corrupt)
          frame[0] = 1'b0;
        for (int i = 0; i < 12; i++)
        begin
          link_data = frame[i];
          #80 link_clk = 1'b1;
          #80 link_clk = 1'b0;
        end
        if (!sync_request_a)
          count_reg = count_reg + 10'h001;
      end
    end
  end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import deser_pkg::*;
  logic mclk, resetn, gsl_n, oen, hiz_n, bist;
  ch_vec_t sl_n, en, bad, doe, rck, coe, lk, loe, xcap;
  wire ch_vec_t lclk;
  wire ch_vec_t ldat;
  logic [59:0] dat;
  result_t res;
  logic [9:0] w1, w2;
  int n_mismatch = 0;
  int check_count = 0;

  deser_control #(.BIST_FRAMES(20)) dut (.MCLK(mclk), .RESETN(resetn), .LINK_CLK(lclk),
    .LINK_DATA(ldat), .CHANNEL_SLEEP_N(sl_n), .GLOBAL_SLEEP_N(gsl_n),
    .OUTPUT_DRIVE_ENABLE(oen), .SCAN_HIGHZ_N(hiz_n), .SCAN_SELFTEST_ACTIVE(bist),
    .RECOVERED_DATA_OUT(dat), .RECOVERED_DATA_OE(doe), .CHANNEL_RECOVERED_CLOCK(rck),
    .CHANNEL_RECOVERED_CLOCK_OE(coe), .CHANNEL_LOCK_N(lk), .CHANNEL_LOCK_N_OE(loe),
    .SELFTEST_RESULT_CHAIN(res), .EXTEST_CAPTURE(xcap));

  for (genvar c = 0; c < 6; c++)
  begin : g_ser
    // lock wire floats when not driven; sync input then reads low
    serializer_model ser (.enable(en[c]), .corrupt(bad[c]),
      .sync_request_a(loe[c] ? lk[c] : 1'b0), .link_clk(lclk[c]),
      .link_data(ldat[c]));
  end

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check_bits(input string what, input logic [59:0] exp, input logic [59:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_oe(input ch_vec_t de, ce, le);
    check_bits("data_oe", 60'(de), 60'(doe));
    check_bits("clock_oe", 60'(ce), 60'(coe));
    check_bits("lock_oe", 60'(le), 60'(loe));
  endtask

  task automatic check_high;
    check_bits("data", '1, dat);
    check_bits("clock", 60'h3f, 60'(rck));
    check_bits("lock_n", 60'h3f, 60'(lk));
    check_oe('1, '1, '1);
  endtask

  task automatic wait_lock;
    int i;
    i = 0;
    while (lk !== 6'h00 && i < 40000)
    begin
      step(1);
      i++;
    end
    check_bits("lock_n", 60'h0, 60'(lk));
  endtask

  task automatic next_word(input int c, output logic [9:0] w);
    int i;
    i = 0;
    while (rck[c] !== 1'b1 && i < 500)
    begin
      step(1);
      i++;
    end
    while (rck[c] !== 1'b0 && i < 1000)
    begin
      step(1);
      i++;
    end
    w = dat[10*c +: 10];
  endtask

  task automatic t_lock;
    check_high;
    check_bits("result", 60'h0, 60'(res));
    gsl_n = 1'b1;
    sl_n = '1;
    oen = 1'b1;
    en = '1;
    step(8);
    check_high;
    wait_lock;
    next_word(0, w1);
    next_word(0, w1);
    next_word(0, w2);
    check_bits("word step", 60'(w1 + 10'h001), 60'(w2));
    $display("test lock done");
  endtask

  task automatic t_enable;
    oen = 1'b0;
    step(8);
    check_oe('0, '0, '1);
    check_bits("lock_n", 60'h0, 60'(lk));
    oen = 1'b1;
    step(8);
    check_oe('1, '1, '1);
    next_word(0, w1);
    next_word(0, w2);
    check_bits("word step", 60'(w1 + 10'h001), 60'(w2));
    $display("test enable done");
  endtask

  task automatic t_sleep;
    oen = 1'b0;
    sl_n = 6'h3b;
    step(8);
    check_bits("ch2 data", 60'h3ff, 60'(dat[29:20]));
    check_bits("clock", 60'h04, 60'(rck & 6'h04));
    check_oe(6'h04, 6'h04, '1);
    check_bits("lock_n", 60'h04, 60'(lk));
    sl_n = '0;
    step(8);
    check_high;
    sl_n = '1;
    oen = 1'b1;
    step(8);
    check_high;
    wait_lock;
    $display("test sleep done");
  endtask

  task automatic t_loss;
    int i;
    next_word(1, w1);
    bad = 6'h02;
    step(100);
    bad = '0;
    step(400);
    check_bits("lock_n", 60'h0, 60'(lk));
    next_word(1, w1);
    bad = 6'h02;
    step(300);
    bad = '0;
    i = 0;
    while (lk[1] !== 1'b1 && i < 600)
    begin
      step(1);
      i++;
    end
    step(2);
    check_bits("lock_n", 60'h02, 60'(lk));
    check_bits("ch1 data", 60'h3ff, 60'(dat[19:10]));
    wait_lock;
    $display("test loss done");
  endtask

  task automatic t_bist;
    int i;
    next_word(5, w1);
    // partner is already sending its counting pattern, so only the receiver's test is started here
    bist = 1'b1;
    bad = 6'h20;
    step(100);
    bad = '0;
    check_oe('0, '0, '0);
    i = 0;
    while ((res & 12'haaa) !== 12'haaa && i < 12000)
    begin
      step(1);
      i++;
    end
    step(2);
    check_bits("result", 60'hbff, 60'(res));
    bist = 1'b0;
    $display("test selftest done");
  endtask

  task automatic t_scan;
    en = '0;
    oen = 1'b0;
    hiz_n = 1'b0;
    gsl_n = 1'b0;
    step(300);
    check_oe('0, '0, '0);
    check_bits("extest", 60'h3f, 60'(xcap));
    hiz_n = 1'b1;
    step(8);
    check_high;
    $display("test scan done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    // three relocks of about 20000 clocks each dominate; this allows about 95000 clocks
    #760000;
    n_mismatch++;
    stop_test;
  end

  initial
  begin
    resetn = 1'b0;
    gsl_n = 1'b0;
    sl_n = '0;
    oen = 1'b0;
    hiz_n = 1'b1;
    bist = 1'b0;
    en = '0;
    bad = '0;
    step(4);
    resetn = 1'b1;
    step(8);
    t_lock;
    t_enable;
    t_sleep;
    t_loss;
    t_bist;
    t_scan;
    stop_test;
  end
endmodule
